/* File: common/sfrtb_defines.svh */
`ifndef SFRTB_DEFINES_SVH
`define SFRTB_DEFINES_SVH
// ---------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------
`define SFRTB_OFF_SETUP0   8'h00
`define SFRTB_OFF_COUNTS   8'h04
`define SFRTB_OFF_OPMODE   8'h08
`define SFRTB_OFF_CTRL     8'h0C
`define SFRTB_OFF_ADDR     8'h10
`define SFRTB_OFF_DATA     8'h14
// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define SFRTB_B_BYPASS     31
`define SFRTB_B_POL        14
`define SFRTB_B_OVRD       31
`define SFRTB_B_ALANE      28
`define SFRTB_B_UNIT       27
`define SFRTB_B_GO         0
`define SFRTB_B_ERR        1
// ---------------------------------------------------------------
// Reset values and built-in command constants.
// ---------------------------------------------------------------
`define SFRTB_SETUP0_RST   32'h8000_0005
`define SFRTB_CMD_DEFAULT  4'h5
`define SFRTB_OP_READ      8'h03
`define SFRTB_OP_FAST      8'h0B
`define SFRTB_OP_DUALO     8'h3B
`define SFRTB_OP_QUADO     8'h6B
`define SFRTB_OP_DUALIO    8'hBB
`define SFRTB_OP_QUADIO    8'hEB
`define SFRTB_OP_WORDQ     8'hE7
`define SFRTB_OP_OCTQ      8'hE3
`define SFRTB_MODE_CONT    8'h20
`define SFRTB_MODE_EXIT    8'hFF
`define SFRTB_SCLK_HALF    4
`endif

/* File: common/sfrtb_pkg.sv */
package sfrtb_pkg;
  typedef enum logic [2:0] {
    SFRTB_ST_IDLE, SFRTB_ST_LOAD, SFRTB_ST_SHIFT,
    SFRTB_ST_DATA, SFRTB_ST_PUSH, SFRTB_ST_END
  } sfrtb_state_t;
  // Transfer description built from a command type or the override.
  typedef struct packed {
    logic [15:0] op;
    logic [1:0]  op_cnt;
    logic [2:0]  ad_cnt;
    logic [15:0] md;
    logic [1:0]  md_cnt;
    logic [1:0]  dm_cnt;
    logic [1:0]  dlane;
    logic        alane;
    logic        unit4;
    logic        bad;
  } sfrtb_xfer_t;
endpackage : sfrtb_pkg

/* File: core/sfrtb_fifo2.sv */
`timescale 1ns/1ps
`default_nettype none
module sfrtb_fifo2
  import sfrtb_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Filling side.
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side.
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          push, pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (cnt_r != CW'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update.
  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule : sfrtb_fifo2
`default_nettype wire

/* File: core/sfrtb_top.sv */
// Contract
// [RULE1] Default read built from command type 0101.
// [RULE2] Codes 0-3: read, fast, dual out, quad out.
// [RULE3] Codes 4-7: dual/quad I/O, odd continuous.
// [RULE4] Codes 8-B word/octal quad; others reserved.
// [RULE5] Override builds transfer from manual fields.
// [RULE6] Software programs all manual fields first.
// [RULE7] Data lanes: one, two, four; 3 reserved.
// [RULE8] Address on one lane or data lanes.
// [RULE9] Serial unit is one or four bytes.
// [RULE10] Zero to two dummy bytes, driven zero.
// [RULE11] Zero to two mode bytes sent.
// [RULE12] Zero to four address bytes sent.
// [RULE13] Zero to two opcode bytes sent.
// [RULE14] Mode bits: upper byte first, then low.
// [RULE15] Opcode: upper byte first, then low.
// [RULE16] Bypass bit forces default controller setup.
// [RULE17] Serial clock idles at polarity level.
// [RULE18] One select; opcode, address, mode, dummy, data.
// [RULE19] Reserved codes refused, no transfer started.
`include "sfrtb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sfrtb_top
  import sfrtb_pkg::*;
#(
  parameter int HALF = `SFRTB_SCLK_HALF
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Flash link.
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_o,
  input  wire logic [3:0]  io_i
);
  // ---------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------
  localparam int CW = $clog2(2 * HALF);
  logic [31:0]  setup0_r, setup0_nxt, counts_r, counts_nxt;
  logic [31:0]  opmode_r, opmode_nxt, addr_r, addr_nxt;
  logic [7:0]   len_r, len_nxt;
  logic         err_r, err_nxt, cont_r, cont_nxt;
  logic         ack_r, ack_nxt;
  logic [31:0]  dat_r, dat_nxt;
  logic [3:0]   io_s1_r, io_s2_r;
  sfrtb_state_t st_r, st_nxt;
  logic [2:0]   ph_r, ph_nxt, lanes_r, lanes_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [31:0]  sh_r, sh_nxt, xa_r, xa_nxt;
  logic [5:0]   bits_r, bits_nxt;
  logic [7:0]   units_r, units_nxt;
  sfrtb_xfer_t  x_r, x_nxt, eff;
  logic         pol_r, pol_nxt;
  logic         req, wr, rd, go, go_ok, pop;
  logic         push_v, push_rdy, fifo_v;
  logic [31:0]  fifo_d;
  logic [2:0]   nbytes;
  logic         last;

  localparam logic [2:0] PH_OP = 3'd0;
  localparam logic [2:0] PH_AD = 3'd1;
  localparam logic [2:0] PH_MD = 3'd2;
  localparam logic [2:0] PH_DM = 3'd3;
  localparam logic [2:0] PH_DT = 3'd4;

  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  // Byte-lane merge for Wishbone select.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Lane code to lane count; code 3 never reaches here.
  function automatic logic [2:0] lanes(input logic [1:0] c);
    return (c == 2'd0) ? 3'd1 : (c == 2'd1) ? 3'd2 : 3'd4;
  endfunction : lanes

  // Built-in command table.
  function automatic sfrtb_xfer_t builtin(input logic [3:0] c, input logic cont);
    sfrtb_xfer_t x;
    x        = '0;
    x.op_cnt = 2'd1;
    x.ad_cnt = 3'd3;
    x.md     = {8'h00, c[0] ? `SFRTB_MODE_CONT : `SFRTB_MODE_EXIT};
    unique case (c)
      4'h0: x.op[7:0] = `SFRTB_OP_READ; // see [RULE2]
      4'h1: begin
        x.op[7:0] = `SFRTB_OP_FAST;
        x.dm_cnt  = 2'd1;
      end
      4'h2, 4'h3: begin
        x.op[7:0] = c[0] ? `SFRTB_OP_QUADO : `SFRTB_OP_DUALO;
        x.dm_cnt  = 2'd1;
        x.dlane   = c[0] ? 2'd2 : 2'd1;
      end
      4'h4, 4'h5: begin
        x.op[7:0] = `SFRTB_OP_DUALIO; // see [RULE3]
        x.dlane   = 2'd1;
        x.alane   = 1'b1;
        x.md_cnt  = 2'd1;
      end
      4'h6, 4'h7: begin
        x.op[7:0] = `SFRTB_OP_QUADIO;
        x.dlane   = 2'd2;
        x.alane   = 1'b1;
        x.md_cnt  = 2'd1;
        x.dm_cnt  = 2'd2;
      end
      4'h8, 4'h9, 4'hA, 4'hB: begin
        x.op[7:0] = c[1] ? `SFRTB_OP_OCTQ : `SFRTB_OP_WORDQ; // see [RULE4]
        x.dlane   = 2'd2;
        x.alane   = 1'b1;
        x.md_cnt  = 2'd1;
        x.dm_cnt  = c[1] ? 2'd0 : 2'd1;
      end
      default: x.bad = 1'b1; // see [RULE19]
    endcase
    // A flash already in continuous mode takes no opcode.
    if (c[0] && cont && c > 4'h4) x.op_cnt = 2'd0;
    return x;
  endfunction : builtin

  // ---------------------------------------------------------------
  // Transfer description selection.
  // ---------------------------------------------------------------
  // The bypass bit wins over both the command type and the override.
  always_comb begin
    if (setup0_r[`SFRTB_B_BYPASS]) begin
      eff = builtin(`SFRTB_CMD_DEFAULT, cont_r); // see [RULE16] see [RULE1]
    end else if (counts_r[`SFRTB_B_OVRD]) begin
      eff        = '0; // see [RULE5]
      eff.op     = opmode_r[15:0];
      eff.op_cnt = counts_r[1:0];
      eff.ad_cnt = counts_r[6:4];
      eff.md     = opmode_r[31:16];
      eff.md_cnt = counts_r[9:8];
      eff.dm_cnt = counts_r[13:12];
      eff.dlane  = counts_r[30:29];
      eff.alane  = counts_r[`SFRTB_B_ALANE];
      eff.unit4  = counts_r[`SFRTB_B_UNIT];
      // Reserved codes in any field refuse the start.
      eff.bad    = (counts_r[30:29] == 2'd3) | (counts_r[13:12] == 2'd3) |
                   (counts_r[9:8] == 2'd3) | (counts_r[6:4] > 3'd4) |
                   (counts_r[1:0] == 2'd3); // see [RULE19]
    end else begin
      eff = builtin(setup0_r[3:0], cont_r); // see [RULE1]
    end
  end

  // ---------------------------------------------------------------
  // Wishbone register file.
  // ---------------------------------------------------------------
  assign req   = cyc_i & stb_i & ~ack_r;
  assign wr    = req & we_i;
  assign rd    = req & ~we_i;
  assign go    = wr & (adr_i[7:0] == `SFRTB_OFF_CTRL) & sel_i[0] & dat_i[`SFRTB_B_GO];
  assign go_ok = go & (st_r == SFRTB_ST_IDLE) & ~eff.bad;
  assign pop   = rd & (adr_i[7:0] == `SFRTB_OFF_DATA) & fifo_v;

  // Writes land in the cycle the answer is raised; a start while busy is dropped.
  always_comb begin
    ack_nxt    = req;
    setup0_nxt = setup0_r;
    counts_nxt = counts_r;
    opmode_nxt = opmode_r;
    addr_nxt   = addr_r;
    len_nxt    = len_r;
    err_nxt    = err_r;
    dat_nxt    = dat_r;
    if (wr) begin
      unique case (adr_i[7:0])
        `SFRTB_OFF_SETUP0: setup0_nxt = merge(setup0_r, dat_i, sel_i);
        `SFRTB_OFF_COUNTS: counts_nxt = merge(counts_r, dat_i, sel_i);
        `SFRTB_OFF_OPMODE: opmode_nxt = merge(opmode_r, dat_i, sel_i);
        `SFRTB_OFF_ADDR:   addr_nxt   = merge(addr_r, dat_i, sel_i);
        `SFRTB_OFF_CTRL: begin
          if (sel_i[1]) len_nxt = dat_i[15:8];
          if (sel_i[0] && dat_i[`SFRTB_B_ERR]) err_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    // A refused start sets the error flag, and that set beats a clear.
    if (go && (st_r == SFRTB_ST_IDLE) && eff.bad) err_nxt = 1'b1; // see [RULE19]
    if (rd) begin
      unique case (adr_i[7:0])
        `SFRTB_OFF_SETUP0: dat_nxt = setup0_r;
        `SFRTB_OFF_COUNTS: dat_nxt = counts_r;
        `SFRTB_OFF_OPMODE: dat_nxt = opmode_r;
        `SFRTB_OFF_ADDR:   dat_nxt = addr_r;
        `SFRTB_OFF_CTRL:   dat_nxt = {16'h0000, len_r, 5'h00, fifo_v, err_r,
                                      st_r != SFRTB_ST_IDLE};
        `SFRTB_OFF_DATA:   dat_nxt = fifo_v ? fifo_d : 32'h0000_0000;
        default:           dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      setup0_r <= `SFRTB_SETUP0_RST;
      counts_r <= 32'h0000_0000;
      opmode_r <= 32'h0000_0000;
      addr_r   <= 32'h0000_0000;
      len_r    <= 8'h00;
      err_r    <= 1'b0;
      dat_r    <= 32'h0000_0000;
    end else begin
      ack_r    <= ack_nxt;
      setup0_r <= setup0_nxt;
      counts_r <= counts_nxt;
      opmode_r <= opmode_nxt;
      addr_r   <= addr_nxt;
      len_r    <= len_nxt;
      err_r    <= err_nxt;
      dat_r    <= dat_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ---------------------------------------------------------------
  // Input synchroniser for the flash data lines.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    io_s1_r <= io_i;
    io_s2_r <= io_s1_r;
  end

  // ---------------------------------------------------------------
  // Transfer sequencer.
  // ---------------------------------------------------------------
  // The serial clock is a divided copy of clk_i; the slow rate leaves room
  // for the two-stage input synchroniser before each sample is taken.
  assign last = (cnt_r == CW'(2 * HALF - 1));

  // Byte count of the phase being loaded.
  always_comb begin
    unique case (ph_r)
      PH_OP:   nbytes = {1'b0, x_r.op_cnt}; // see [RULE13]
      PH_AD:   nbytes = x_r.ad_cnt; // see [RULE12]
      PH_MD:   nbytes = {1'b0, x_r.md_cnt}; // see [RULE11]
      PH_DM:   nbytes = {1'b0, x_r.dm_cnt}; // see [RULE10]
      default: nbytes = 3'd0;
    endcase
  end

  always_comb begin
    st_nxt    = st_r;
    ph_nxt    = ph_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    bits_nxt  = bits_r;
    units_nxt = units_r;
    lanes_nxt = lanes_r;
    x_nxt     = x_r;
    xa_nxt    = xa_r;
    pol_nxt   = setup0_r[`SFRTB_B_BYPASS] ? 1'b0 : setup0_r[`SFRTB_B_POL];
    cont_nxt  = cont_r;
    push_v    = 1'b0;
    unique case (st_r)
      SFRTB_ST_IDLE: begin
        if (go_ok) begin
          x_nxt     = eff;
          xa_nxt    = addr_r;
          units_nxt = sel_i[1] ? dat_i[15:8] : len_r; // Count written with go applies.
          ph_nxt    = PH_OP;
          st_nxt    = SFRTB_ST_LOAD; // see [RULE18]
          cont_nxt  = ~setup0_r[`SFRTB_B_BYPASS] & ~counts_r[`SFRTB_B_OVRD] &
                      setup0_r[0] & (setup0_r[3:0] > 4'h4) & (setup0_r[3:0] < 4'hC);
        end
      end
      SFRTB_ST_LOAD: begin
        cnt_nxt  = '0;
        bits_nxt = {nbytes, 3'b000};
        lanes_nxt = x_r.alane ? lanes(x_r.dlane) : 3'd1; // see [RULE8]
        unique case (ph_r)
          PH_OP: begin
            lanes_nxt = 3'd1;
            sh_nxt = (x_r.op_cnt == 2'd2) ? {x_r.op, 16'h0000}
                                          : {x_r.op[7:0], 24'h000000}; // see [RULE15]
          end
          PH_AD: begin
            unique case (x_r.ad_cnt)
              3'd1:    sh_nxt = {xa_r[7:0], 24'h000000};
              3'd2:    sh_nxt = {xa_r[15:0], 16'h0000};
              3'd3:    sh_nxt = {xa_r[23:0], 8'h00};
              default: sh_nxt = xa_r;
            endcase
          end
          PH_MD: sh_nxt = (x_r.md_cnt == 2'd2) ? {x_r.md, 16'h0000}
                                               : {x_r.md[7:0], 24'h000000}; // see [RULE14]
          PH_DM: sh_nxt = 32'h0000_0000; // see [RULE10]
          default: begin
            sh_nxt    = 32'h0000_0000;
            lanes_nxt = lanes(x_r.dlane); // see [RULE7]
            bits_nxt  = x_r.unit4 ? 6'd32 : 6'd8; // see [RULE9]
          end
        endcase
        if (ph_r == PH_DT) begin
          st_nxt = SFRTB_ST_DATA;
        end else if (nbytes == 3'd0) begin
          ph_nxt = ph_r + 3'd1;
        end else begin
          st_nxt = SFRTB_ST_SHIFT;
        end
      end
      SFRTB_ST_SHIFT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (last) begin
          cnt_nxt  = '0;
          sh_nxt   = sh_r << lanes_r;
          bits_nxt = bits_r - {3'b000, lanes_r};
          if (bits_r == {3'b000, lanes_r}) begin
            ph_nxt = ph_r + 3'd1; // see [RULE18]
            st_nxt = SFRTB_ST_LOAD;
          end
        end
      end
      SFRTB_ST_DATA: begin
        cnt_nxt = cnt_r + 1'b1;
        if (last) begin
          cnt_nxt = '0;
          unique case (lanes_r)
            3'd1:    sh_nxt = {sh_r[30:0], io_s2_r[1]};
            3'd2:    sh_nxt = {sh_r[29:0], io_s2_r[1:0]};
            default: sh_nxt = {sh_r[27:0], io_s2_r};
          endcase
          bits_nxt = bits_r - {3'b000, lanes_r};
          if (bits_r == {3'b000, lanes_r}) st_nxt = SFRTB_ST_PUSH;
        end
      end
      SFRTB_ST_PUSH: begin
        // The serial clock stays idle until the buffer takes the word.
        push_v = 1'b1;
        if (push_rdy) begin
          sh_nxt   = 32'h0000_0000;
          bits_nxt = x_r.unit4 ? 6'd32 : 6'd8;
          if (units_r == 8'h00) begin
            st_nxt = SFRTB_ST_END; // see [RULE18]
          end else begin
            units_nxt = units_r - 8'h01;
            st_nxt    = SFRTB_ST_DATA;
          end
        end
      end
      SFRTB_ST_END: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(HALF - 1)) begin
          cnt_nxt = '0;
          st_nxt  = SFRTB_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= SFRTB_ST_IDLE;
      ph_r    <= PH_OP;
      cnt_r   <= '0;
      sh_r    <= 32'h0000_0000;
      bits_r  <= 6'd0;
      units_r <= 8'h00;
      lanes_r <= 3'd1;
      x_r     <= '0;
      xa_r    <= 32'h0000_0000;
      pol_r   <= 1'b0;
      cont_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ph_r    <= ph_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      bits_r  <= bits_nxt;
      units_r <= units_nxt;
      lanes_r <= lanes_nxt;
      x_r     <= x_nxt;
      xa_r    <= xa_nxt;
      pol_r   <= pol_nxt;
      cont_r  <= cont_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive.
  // ---------------------------------------------------------------
  // Lines are driven only while shifting out; data lines float back to the flash.
  assign cs_n_o  = (st_r == SFRTB_ST_IDLE) | (st_r == SFRTB_ST_END); // see [RULE18]
  assign sclk_o  = pol_r ^ (((st_r == SFRTB_ST_SHIFT) | (st_r == SFRTB_ST_DATA)) &
                   (cnt_r >= CW'(HALF))); // see [RULE17]
  assign io_oe_o = (st_r != SFRTB_ST_SHIFT) ? 4'h0 :
                   (lanes_r == 3'd1) ? 4'h1 : (lanes_r == 3'd2) ? 4'h3 : 4'hF;
  assign io_o    = (lanes_r == 3'd1) ? {3'b000, sh_r[31]} :
                   (lanes_r == 3'd2) ? {2'b00, sh_r[31:30]} : sh_r[31:28];

  // Read data buffer; a full buffer stalls the sequencer.
  sfrtb_fifo2 #(.W(32), .DEPTH(2)) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_v),
    .in_ready_o  (push_rdy),
    .in_data_i   (sh_r),
    .out_valid_o (fifo_v),
    .out_ready_i (pop),
    .out_data_o  (fifo_d)
  );

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    go_ok;
  endsequence
  sequence s_select;
    ##1 (!cs_n_o && st_r == SFRTB_ST_LOAD && ph_r == PH_OP);
  endsequence

  chk_start_select: assert property (s_start |-> s_select) // see [RULE18]
    else $error("Accepted start did not assert select.");
  chk_refuse_bad: assert property (go && eff.bad && st_r == SFRTB_ST_IDLE |=> cs_n_o && err_r) // see [RULE19]
    else $error("Reserved setup started a transfer.");
  chk_sclk_idle: assert property (cs_n_o |-> sclk_o == pol_r) // see [RULE17]
    else $error("Serial clock not at idle level.");
  chk_dummy_zero: assert property (st_r == SFRTB_ST_SHIFT && ph_r == PH_DM |-> io_o == 4'h0) // see [RULE10]
    else $error("Dummy byte not driven zero.");
  chk_data_float: assert property (st_r == SFRTB_ST_DATA |-> io_oe_o == 4'h0) // see [RULE7]
    else $error("Lines driven during read data.");
  chk_phase_order: assert property (!cs_n_o && $past(!cs_n_o) |-> ph_r >= $past(ph_r)) // see [RULE18]
    else $error("Phase order went backwards.");
  chk_addr_lane: assert property (st_r == SFRTB_ST_SHIFT && ph_r == PH_AD && !x_r.alane |-> io_oe_o == 4'h1) // see [RULE8]
    else $error("Address not on one lane.");
  chk_reset_cmd: assert property ($fell(rst_i) |-> setup0_r[3:0] == 4'h5 && !counts_r[31]) // see [RULE1]
    else $error("Command type reset value wrong.");
  chk_push_held: assert property (push_v && !push_rdy |=> push_v && sh_r == $past(sh_r)) // see [RULE9]
    else $error("Word lost under back-pressure.");
  chk_end_gap: assert property ($rose(cs_n_o) |-> cs_n_o [*4]) // see [RULE18]
    else $error("Select high gap too short.");
endmodule : sfrtb_top
`default_nettype wire

/* File: sim/sfrtb_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfrtb_flash_model #(
  parameter logic [7:0] PAT = 8'hA5
) (
  // Link from the block.
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  input  wire logic [3:0] io_oe_i,
  // Answer lines.
  output logic [3:0]      io_o
);
  logic [127:0] cap = '0;
  logic [7:0]   first8 = '0;
  int           nbits = 0;
  int           nxfer = 0;
  int           k = 0;
  initial io_o = 4'h0;
  // A new frame restarts the answer pattern.
  always @(negedge cs_n_i) begin
    k = 0;
    nbits = 0;
    nxfer++;
    io_o = {4{PAT[7]}};
  end
  // Answer bits move on the falling edge so the block has half a bit to sample.
  always @(negedge sclk_i) if (!cs_n_i) begin
    k++;
    io_o = {4{PAT[7 - (k % 8)]}};
  end
  // Everything the block drives on lane 0 is recorded, dummies included.
  always @(posedge sclk_i) if (!cs_n_i && io_oe_i[0]) begin
    cap = {cap[126:0], io_i[0]};
    nbits++;
    if (nbits == 8) first8 = cap[7:0];
  end
  // A released line must not keep its last value.
  always @(posedge cs_n_i) io_o = ~io_o;
endmodule : sfrtb_flash_model
`default_nettype wire

/* File: sim/tb_sfrtb_top.sv */
`include "sfrtb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_sfrtb_top;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [31:0]  adr = '0;
  logic [31:0]  dat = '0;
  logic [31:0]  dat_o;
  logic         ack_o, sclk_o, cs_n_o;
  logic [3:0]   io_o, io_oe_o, fl_o, io_w;
  int           n_mismatch = 0;
  int           compares = 0;
  logic [7:0]   ops [12] = '{`SFRTB_OP_READ, `SFRTB_OP_FAST, `SFRTB_OP_DUALO, `SFRTB_OP_QUADO,
    `SFRTB_OP_DUALIO, `SFRTB_OP_DUALIO, `SFRTB_OP_QUADIO, `SFRTB_OP_QUADIO,
    `SFRTB_OP_WORDQ, `SFRTB_OP_WORDQ, `SFRTB_OP_OCTQ, `SFRTB_OP_OCTQ};
  always #20 clk_i = ~clk_i;
  // Each lane carries whoever has its enable up.
  assign io_w = (io_oe_o & io_o) | (~io_oe_o & fl_o);
  sfrtb_top #(.HALF(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .sclk_o(sclk_o), .cs_n_o(cs_n_o), .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_w));
  sfrtb_flash_model flash (.sclk_i(sclk_o), .cs_n_i(cs_n_o), .io_i(io_o),
    .io_oe_i(io_oe_o), .io_o(fl_o));
  task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Classic cycle: hold everything until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h0, a};
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    do begin
      wb(1'b0, `SFRTB_OFF_CTRL, 32'h0, r);
    end while (r[b] !== v);
  endtask : poll
  // Bytes the block should shift before the data phase, oldest first.
  function automatic logic [127:0] hdr(input logic [15:0] op, input int oc,
    input logic [31:0] ad, input int ac, input logic [15:0] md, input int mc,
    input int dc, output int n);
    logic [127:0] r;
    r = '0;
    n = 8 * (oc + ac + mc + dc);
    if (oc == 2) r = {r[119:0], op[15:8]};
    if (oc > 0) r = {r[119:0], op[7:0]};
    for (int i = ac - 1; i >= 0; i--) r = {r[119:0], ad[8*i +: 8]};
    if (mc == 2) r = {r[119:0], md[15:8]};
    if (mc > 0) r = {r[119:0], md[7:0]};
    for (int i = 0; i < dc; i++) r = {r[119:0], 8'h00};
    return r;
  endfunction : hdr
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Cuts a hang short well inside the cycle budget.
  initial begin
    #(40 * 90000);
    n_mismatch++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    logic [31:0] r, ad;
    logic [15:0] op, md;
    logic [127:0] e, m;
    int n, oc, ac, mc, dc, u, x;
    void'($urandom(32'hC085C36A));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `SFRTB_OFF_SETUP0, 32'h0, r);
    chk("setup0", 32'h8000_0005, r);
    wb(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    $display("test reset done");
    // Bypass wins over a cleared command field, then codes 0 to 11 in turn.
    for (int c = -1; c < 12; c++) begin
      wb(1'b1, `SFRTB_OFF_SETUP0, (c < 0) ? 32'h8000_0000 : c, r);
      wb(1'b1, `SFRTB_OFF_CTRL, 32'h1, r);
      poll(0, 1'b0);
      wb(1'b0, `SFRTB_OFF_DATA, 32'h0, r);
      chk("op", (c < 0) ? `SFRTB_OP_DUALIO : ops[c], flash.first8);
    end
    $display("test command types done");
    // A reserved lane code must start no frame.
    x = flash.nxfer;
    wb(1'b1, `SFRTB_OFF_COUNTS, 32'hE000_0001, r);
    wb(1'b1, `SFRTB_OFF_CTRL, 32'h1, r);
    wb(1'b0, `SFRTB_OFF_CTRL, 32'h0, r);
    chk("error flag", 1'b1, r[1]);
    chk("frames", x, flash.nxfer);
    wb(1'b1, `SFRTB_OFF_CTRL, 32'h2, r);
    $display("test reserved done");
    // Manual transfers; the first one takes every count at its maximum.
    for (int i = 0; i < 8; i++) begin
      oc = (i == 0) ? 2 : $urandom_range(2, 0);
      ac = (i == 0) ? 4 : $urandom_range(4, 0);
      mc = (i == 0) ? 2 : $urandom_range(2, 0);
      dc = (i == 0) ? 2 : $urandom_range(2, 0);
      u = (i == 0) ? 4 : $urandom_range(4, 1);
      op = 16'($urandom);
      md = 16'($urandom);
      ad = $urandom;
      wb(1'b1, `SFRTB_OFF_COUNTS, 32'h8000_0000 | (dc << 12) | (mc << 8) | (ac << 4) | oc, r);
      wb(1'b1, `SFRTB_OFF_OPMODE, {md, op}, r);
      wb(1'b1, `SFRTB_OFF_ADDR, ad, r);
      wb(1'b1, `SFRTB_OFF_CTRL, ((u - 1) << 8) | 1, r);
      // Reading late lets the buffer fill, so the sequencer must stall without loss.
      if (i == 0) repeat (1200) @(posedge clk_i);
      for (int j = 0; j < u; j++) begin
        poll(2, 1'b1);
        wb(1'b0, `SFRTB_OFF_DATA, 32'h0, r);
        chk("read data", 32'h0000_00A5, r);
      end
      poll(0, 1'b0);
      e = hdr(op, oc, ad, ac, md, mc, dc, n);
      m = (128'h1 << n) - 128'h1;
      chk("header bits", e & m, flash.cap & m);
      chk("bit count", n, flash.nbits);
      wb(1'b0, `SFRTB_OFF_DATA, 32'h0, r);
      chk("empty read", 32'h0, r);
    end
    $display("test manual done");
    wb(1'b1, `SFRTB_OFF_SETUP0, 32'h0000_4000, r);
    repeat (2) @(posedge clk_i);
    chk("idle high", 1'b1, sclk_o);
    wb(1'b1, `SFRTB_OFF_SETUP0, 32'h0, r);
    repeat (2) @(posedge clk_i);
    chk("idle low", 1'b0, sclk_o);
    $display("test polarity done");
    print_verdict();
  end
endmodule : tb_sfrtb_top
`default_nettype wire
